// ---- src/etpis_pkg.sv ----
package etpis_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 21;
  localparam int unsigned STK_DEPTH = 31;
  localparam int unsigned SP_W = 5;
  localparam int unsigned NEXT = 3;
  localparam int unsigned NCHG = 4;

  localparam logic [ADDR_W-1:0] ADDR_RST_CTL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTLA = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTLB = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CTLC = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_TCTL = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_TLO = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_THI = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_PORT = 4'h7;

  // reset_control_reg fields
  localparam int unsigned RC_PRIO_EN = 7;
  localparam int unsigned RC_RSVD_HI = 6;
  localparam int unsigned RC_RSVD_LO = 5;
  localparam int unsigned RC_RST_INSTR = 4;
  localparam int unsigned RC_WDT_TMO = 3;
  localparam int unsigned RC_PWR_DOWN = 2;
  localparam int unsigned RC_POR = 1;
  localparam int unsigned RC_BROWNOUT = 0;
  localparam logic [DATA_W-1:0] RC_RST = 8'h1c;

  // irq_control_a fields
  localparam int unsigned CA_GIEH = 7;
  localparam int unsigned CA_GIEL = 6;
  localparam int unsigned CA_TOIE = 5;
  localparam int unsigned CA_E0IE = 4;
  localparam int unsigned CA_PCIE = 3;
  localparam int unsigned CA_TOIF = 2;
  localparam int unsigned CA_E0IF = 1;
  localparam int unsigned CA_PCIF = 0;

  // irq_control_b fields
  localparam int unsigned CB_EDG0 = 7;
  localparam int unsigned CB_EDG1 = 6;
  localparam int unsigned CB_EDG2 = 5;
  localparam int unsigned CB_TOIP = 2;
  localparam int unsigned CB_PCIP = 0;
  localparam logic [DATA_W-1:0] CB_RST = 8'he5;

  // irq_control_c fields
  localparam int unsigned CC_E2IP = 7;
  localparam int unsigned CC_E1IP = 6;
  localparam int unsigned CC_E2IE = 4;
  localparam int unsigned CC_E1IE = 3;
  localparam int unsigned CC_E2IF = 1;
  localparam int unsigned CC_E1IF = 0;
  localparam logic [DATA_W-1:0] CC_RST = 8'hc0;

  // Timer control fields
  localparam int unsigned TC_ON = 7;
  localparam int unsigned TC_8BIT = 6;
  localparam logic [DATA_W-1:0] TC_RST = 8'h40;
endpackage

// ---- src/etpis_top.sv ----
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Reset control register: reset cause, priority enable
// RULE_02 - Layout: priority enable, reset-cause flags
// RULE_03 - Enable one: two levels; zero: single level
// RULE_04 - Bits six and five read zero
// RULE_05 - External pins trigger on edges only
// RULE_06 - Edge select one rising, zero falling
// RULE_07 - Valid edge sets that pin's flag
// RULE_08 - Cleared enable disables external interrupt
// RULE_09 - Software clears flag before re-enabling
// RULE_10 - Enabled external interrupt wakes idle/sleep
// RULE_11 - After wake, vector if global enable set
// RULE_12 - Pin1/pin2 priority from control C bits
// RULE_13 - Pin zero always high priority
// RULE_14 - 8-bit timer all-ones to zero sets flag
// RULE_15 - 16-bit timer wrap sets same flag
// RULE_16 - Timer enable A bit5, priority B bit2
// RULE_17 - Change on four port pins sets flag
// RULE_18 - Port enable A bit3, priority B bit0
// RULE_19 - Entry pushes return PC on stack
// RULE_20 - Entry shadows working, status, bank regs
// RULE_21 - Without fast return software saves context
// RULE_22 - Flags sticky; request while flag and enable
module etpis_top
  import etpis_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [NEXT-1:0] ext_irq_pin_i,
  input wire logic [NCHG-1:0] change_port_i,
  input wire logic sleep_i,
  input wire logic wdt_timeout_i,
  input wire logic reset_instr_i,
  input wire logic irq_entry_i,
  input wire logic irq_return_i,
  input wire logic fast_return_i,
  input wire logic [PC_W-1:0] return_pc_i,
  input wire logic [DATA_W-1:0] working_reg_i,
  input wire logic [DATA_W-1:0] status_reg_i,
  input wire logic [DATA_W-1:0] bank_select_reg_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic irq_high_o,
  output logic irq_low_o,
  output logic wake_o,
  output logic [PC_W-1:0] stack_top_o,
  output logic stack_full_o,
  output logic restore_valid_o,
  output logic [DATA_W-1:0] working_reg_o,
  output logic [DATA_W-1:0] status_reg_o,
  output logic [DATA_W-1:0] bank_select_reg_o
);

  logic [DATA_W-1:0] rst_ctl_r;
  logic [DATA_W-1:0] ctla_r;
  logic [DATA_W-1:0] ctlb_r;
  logic [DATA_W-1:0] ctlc_r;
  logic [DATA_W-1:0] tctl_r;
  logic [DATA_W-1:0] tlo_r;
  logic [DATA_W-1:0] thi_r;
  logic [NEXT-1:0] pin_prev_r;
  logic [NCHG-1:0] port_prev_r;
  logic sleep_prev_r;
  logic pin_seen_r;
  logic [NEXT-1:0] wake_en_r;
  logic [PC_W-1:0] stack_mem [0:STK_DEPTH-1];
  logic [SP_W-1:0] sp_r;

  logic wr_rst_ctl;
  logic wr_ctla;
  logic wr_ctlb;
  logic wr_ctlc;
  logic wr_tctl;
  logic wr_tlo;
  logic wr_thi;
  logic [NEXT-1:0] edge_sel;
  logic [NEXT-1:0] ext_edge;
  logic [NEXT-1:0] ext_flag;
  logic [NEXT-1:0] ext_en;
  logic port_change;
  logic tmr_ovf;
  logic [DATA_W-1:0] rd_nxt;
  logic [NEXT-1:0] req_ext;
  logic req_tmr;
  logic req_port;
  logic any_high;
  logic any_low;
  logic stk_push;
  logic stk_pop;

  always_comb begin
    wr_rst_ctl = 1'b0;
    wr_ctla = 1'b0;
    wr_ctlb = 1'b0;
    wr_ctlc = 1'b0;
    wr_tctl = 1'b0;
    wr_tlo = 1'b0;
    wr_thi = 1'b0;
    if (!wr_i) begin
      wr_rst_ctl = 1'b0;
    end else if (addr_i == ADDR_RST_CTL) begin
      wr_rst_ctl = 1'b1;
    end else if (addr_i == ADDR_CTLA) begin
      wr_ctla = 1'b1;
    end else if (addr_i == ADDR_CTLB) begin
      wr_ctlb = 1'b1;
    end else if (addr_i == ADDR_CTLC) begin
      wr_ctlc = 1'b1;
    end else if (addr_i == ADDR_TCTL) begin
      wr_tctl = 1'b1;
    end else if (addr_i == ADDR_TLO) begin
      wr_tlo = 1'b1;
    end else if (addr_i == ADDR_THI) begin
      wr_thi = 1'b1;
    end
  end

  // Edge detection against the previous sample, so a held level never retriggers
  assign edge_sel = {ctlb_r[CB_EDG2], ctlb_r[CB_EDG1], ctlb_r[CB_EDG0]};
  // No edge before the first sample: pins may idle at either level
  assign ext_edge = {NEXT{pin_seen_r}}
                  & ((ext_irq_pin_i & ~pin_prev_r & edge_sel)       // [RULE_05] [RULE_06]
                  | (~ext_irq_pin_i & pin_prev_r & ~edge_sel));     // [RULE_05] [RULE_06]
  assign ext_flag = {ctlc_r[CC_E2IF], ctlc_r[CC_E1IF], ctla_r[CA_E0IF]};
  assign ext_en = {ctlc_r[CC_E2IE], ctlc_r[CC_E1IE], ctla_r[CA_E0IE]};
  assign port_change = pin_seen_r & (|(change_port_i ^ port_prev_r)); // [RULE_17]

  always_comb begin
    tmr_ovf = 1'b0;
    if (tctl_r[TC_ON]) begin
      if (tctl_r[TC_8BIT]) begin
        tmr_ovf = &tlo_r; // [RULE_14]
      end else begin
        tmr_ovf = &{thi_r, tlo_r}; // [RULE_15]
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_prev_r <= '0;
      port_prev_r <= '0;
      sleep_prev_r <= 1'b0;
      pin_seen_r <= 1'b0;
    end else if (ce_i) begin
      pin_seen_r <= 1'b1;
      pin_prev_r <= ext_irq_pin_i;
      port_prev_r <= change_port_i;
      sleep_prev_r <= sleep_i;
    end
  end

  // Reset cause: watchdog and power-down flags are hardware-only
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_ctl_r <= RC_RST; // [RULE_01] [RULE_02]
    end else if (ce_i) begin
      if (wr_rst_ctl) begin
        rst_ctl_r[RC_PRIO_EN] <= wdata_i[RC_PRIO_EN]; // [RULE_02]
        rst_ctl_r[RC_RST_INSTR] <= wdata_i[RC_RST_INSTR];
        rst_ctl_r[RC_POR] <= wdata_i[RC_POR];
        rst_ctl_r[RC_BROWNOUT] <= wdata_i[RC_BROWNOUT];
      end
      if (reset_instr_i) begin
        rst_ctl_r[RC_RST_INSTR] <= 1'b0;
      end
      if (wdt_timeout_i) begin
        rst_ctl_r[RC_WDT_TMO] <= 1'b0;
      end
      if (sleep_i && !sleep_prev_r) begin
        rst_ctl_r[RC_PWR_DOWN] <= 1'b0;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctla_r <= '0;
    end else if (ce_i) begin
      if (wr_ctla) begin
        ctla_r <= wdata_i;
      end
      if (tmr_ovf) begin
        ctla_r[CA_TOIF] <= 1'b1; // [RULE_14] [RULE_15] [RULE_22]
      end
      if (ext_edge[0]) begin
        ctla_r[CA_E0IF] <= 1'b1; // [RULE_07] [RULE_22]
      end
      if (port_change) begin
        ctla_r[CA_PCIF] <= 1'b1; // [RULE_17] [RULE_22]
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctlb_r <= CB_RST;
    end else if (ce_i && wr_ctlb) begin
      ctlb_r <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctlc_r <= CC_RST;
    end else if (ce_i) begin
      if (wr_ctlc) begin
        ctlc_r <= wdata_i;
      end
      if (ext_edge[1]) begin
        ctlc_r[CC_E1IF] <= 1'b1; // [RULE_07] [RULE_22]
      end
      if (ext_edge[2]) begin
        ctlc_r[CC_E2IF] <= 1'b1; // [RULE_07] [RULE_22]
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tctl_r <= TC_RST;
    end else if (ce_i && wr_tctl) begin
      tctl_r <= wdata_i;
    end
  end

  // Counter advances every enabled clock while TC_ON is set; a software write takes precedence
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tlo_r <= '0;
      thi_r <= '0;
    end else if (ce_i) begin
      if (tctl_r[TC_ON]) begin
        tlo_r <= tlo_r + 8'h01;
        if (!tctl_r[TC_8BIT] && (&tlo_r)) begin
          thi_r <= thi_r + 8'h01;
        end
      end
      if (wr_tlo) begin
        tlo_r <= wdata_i;
      end
      if (wr_thi) begin
        thi_r <= wdata_i;
      end
    end
  end

  always_comb begin
    rd_nxt = '0;
    if (!rd_i) begin
      rd_nxt = '0;
    end else if (addr_i == ADDR_RST_CTL) begin
      rd_nxt = rst_ctl_r; // [RULE_01]
      rd_nxt[RC_RSVD_HI:RC_RSVD_LO] = '0; // [RULE_04]
    end else if (addr_i == ADDR_CTLA) begin
      rd_nxt = ctla_r;
    end else if (addr_i == ADDR_CTLB) begin
      rd_nxt = ctlb_r;
    end else if (addr_i == ADDR_CTLC) begin
      rd_nxt = ctlc_r;
    end else if (addr_i == ADDR_TCTL) begin
      rd_nxt = tctl_r;
    end else if (addr_i == ADDR_TLO) begin
      rd_nxt = tlo_r;
    end else if (addr_i == ADDR_THI) begin
      rd_nxt = thi_r;
    end else if (addr_i == ADDR_PORT) begin
      rd_nxt = {{(DATA_W-NCHG){1'b0}}, change_port_i};
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else if (ce_i) begin
      rd_data_o <= rd_nxt;
    end
  end

  // Requests and their priority classes
  assign req_ext = ext_flag & ext_en; // [RULE_08] [RULE_22]
  assign req_tmr = ctla_r[CA_TOIF] & ctla_r[CA_TOIE]; // [RULE_16] [RULE_22]
  assign req_port = ctla_r[CA_PCIF] & ctla_r[CA_PCIE]; // [RULE_18] [RULE_22]
  assign any_high = req_ext[0]                          // [RULE_13]
                  | (req_ext[1] & ctlc_r[CC_E1IP])      // [RULE_12]
                  | (req_ext[2] & ctlc_r[CC_E2IP])      // [RULE_12]
                  | (req_tmr & ctlb_r[CB_TOIP])         // [RULE_16]
                  | (req_port & ctlb_r[CB_PCIP]);       // [RULE_18]
  assign any_low = (req_ext[1] & ~ctlc_r[CC_E1IP])
                 | (req_ext[2] & ~ctlc_r[CC_E2IP])
                 | (req_tmr & ~ctlb_r[CB_TOIP])
                 | (req_port & ~ctlb_r[CB_PCIP]);

  // Single-level mode sends every source to the high vector under one enable
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end else if (ce_i) begin
      if (rst_ctl_r[RC_PRIO_EN]) begin
        irq_high_o <= ctla_r[CA_GIEH] & any_high; // [RULE_03] [RULE_11]
        irq_low_o <= ctla_r[CA_GIEH] & ctla_r[CA_GIEL] & any_low; // [RULE_03]
      end else begin
        irq_high_o <= ctla_r[CA_GIEH] & (any_high | any_low); // [RULE_03] [RULE_11]
        irq_low_o <= 1'b0; // [RULE_03]
      end
    end
  end

  // Wake needs the enable as it stood when sleep began
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_en_r <= '0;
      wake_o <= 1'b0;
    end else if (ce_i) begin
      if (sleep_i && !sleep_prev_r) begin
        wake_en_r <= ext_en; // [RULE_10]
      end
      wake_o <= sleep_i & sleep_prev_r & |(ext_flag & wake_en_r); // [RULE_10]
    end
  end

  // Context save; a push onto a full stack is dropped
  assign stk_push = irq_entry_i && (sp_r != SP_W'(STK_DEPTH));
  assign stk_pop = irq_return_i && !irq_entry_i && (sp_r != '0);

  always_ff @(posedge ref_clk_i) begin
    if (ce_i && stk_push) begin
      stack_mem[sp_r] <= return_pc_i; // [RULE_19]
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sp_r <= '0;
      stack_top_o <= '0;
      stack_full_o <= 1'b0;
    end else if (ce_i) begin
      if (stk_push) begin
        sp_r <= sp_r + SP_W'(1); // [RULE_19]
        stack_top_o <= return_pc_i; // [RULE_19]
        stack_full_o <= (sp_r == SP_W'(STK_DEPTH - 1));
      end else if (stk_pop) begin
        sp_r <= sp_r - SP_W'(1);
        stack_full_o <= 1'b0;
        if (sp_r >= SP_W'(2)) begin
          stack_top_o <= stack_mem[sp_r - SP_W'(2)];
        end else begin
          stack_top_o <= '0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      working_reg_o <= '0;
      status_reg_o <= '0;
      bank_select_reg_o <= '0;
      restore_valid_o <= 1'b0;
    end else if (ce_i) begin
      restore_valid_o <= irq_return_i & fast_return_i & !irq_entry_i; // [RULE_20]
      if (irq_entry_i) begin
        working_reg_o <= working_reg_i; // [RULE_20]
        status_reg_o <= status_reg_i; // [RULE_20]
        bank_select_reg_o <= bank_select_reg_i; // [RULE_20]
      end
    end
  end

endmodule // etpis_top

// ---- bench/etpis_pins_model.sv ----
`timescale 1ns/1ps
module etpis_pins_model
  import etpis_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic slow_i,
  input wire logic [NEXT-1:0] ext_lvl_i,
  input wire logic [NCHG-1:0] chg_lvl_i,
  output logic [NEXT-1:0] ext_irq_pin_o,
  output logic [NCHG-1:0] change_port_o
);
  logic [NEXT-1:0] ext_d_r;
  logic [NCHG-1:0] chg_d_r;
  initial begin
    {ext_d_r, chg_d_r, ext_irq_pin_o, change_port_o} = '0;
  end
  // Slow pins settle a cycle late, like a long board trace
  always @(posedge ref_clk_i) begin
    ext_d_r <= ext_lvl_i;
    chg_d_r <= chg_lvl_i;
    ext_irq_pin_o <= slow_i ? ext_d_r : ext_lvl_i;
    change_port_o <= slow_i ? chg_d_r : chg_lvl_i;
  end
endmodule // etpis_pins_model

// ---- bench/etpis_checker.sv ----
`timescale 1ns/1ps
module etpis_checker
  import etpis_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic sleep_i,
  input wire logic irq_entry_i,
  input wire logic irq_return_i,
  input wire logic fast_return_i,
  input wire logic [PC_W-1:0] return_pc_i,
  input wire logic [DATA_W-1:0] working_reg_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic irq_high_o,
  input wire logic irq_low_o,
  input wire logic wake_o,
  input wire logic [PC_W-1:0] stack_top_o,
  input wire logic stack_full_o,
  input wire logic restore_valid_o,
  input wire logic [DATA_W-1:0] working_reg_o
);
  logic prio_en_r;
  logic gie_r;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Mirrors of two control bits, since they are not visible as ports
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prio_en_r <= 1'b0;
      gie_r <= 1'b0;
    end else if (ce_i && wr_i) begin
      if (addr_i == ADDR_RST_CTL) prio_en_r <= wdata_i[RC_PRIO_EN];
      if (addr_i == ADDR_CTLA) gie_r <= wdata_i[CA_GIEH];
    end
  end
  a_read_idle: assert property (!rd_i && ce_i |=> rd_data_o == 8'h00) else $error("stray read data");
  a_rsvd_zero: assert property (rd_i && addr_i == ADDR_RST_CTL |=> rd_data_o[6:5] == 2'h0)
    else $error("reserved bits set");
  a_stack_push: assert property (irq_entry_i && ce_i && !stack_full_o |=> stack_top_o == $past(return_pc_i))
    else $error("return address not pushed");
  a_stack_hold: assert property (!irq_entry_i && !irq_return_i |=> $stable(stack_top_o))
    else $error("stack moved unasked");
  a_shadow_copy: assert property (irq_entry_i && ce_i |=> working_reg_o == $past(working_reg_i))
    else $error("working shadow wrong");
  a_restore_cause: assert property (restore_valid_o |-> $past(irq_return_i) && $past(fast_return_i))
    else $error("restore without fast return");
  a_legacy_low: assert property (!prio_en_r && !$past(prio_en_r) |-> !irq_low_o)
    else $error("low request in single level");
  a_irq_gie: assert property (irq_high_o || irq_low_o |-> $past(gie_r))
    else $error("request without global enable");
  a_wake_sleep: assert property (wake_o |-> $past(sleep_i)) else $error("wake while awake");
  c_low: cover property (irq_low_o);
  c_wake: cover property (wake_o);
  c_restore: cover property (restore_valid_o);
endmodule // etpis_checker

bind etpis_top etpis_checker etpis_checker_i (.ref_clk_i, .sys_rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .sleep_i, .irq_entry_i, .irq_return_i, .fast_return_i, .return_pc_i, .working_reg_i, .rd_data_o, .irq_high_o,
  .irq_low_o, .wake_o, .stack_top_o, .stack_full_o, .restore_valid_o, .working_reg_o);

// ---- bench/etpis_top_tb.sv ----
`timescale 1ns/1ps
module etpis_top_tb
  import etpis_pkg::*;
;
  logic ref_clk_i, sys_rst_i, ce_i, wr_i, rd_i, sleep_i, slow;
  logic wdt_timeout_i, reset_instr_i, irq_entry_i, irq_return_i, fast_return_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, working_reg_i, status_reg_i, bank_select_reg_i;
  logic [DATA_W-1:0] rd_data_o, working_reg_o, status_reg_o, bank_select_reg_o;
  logic [NEXT-1:0] ext_lvl, ext_irq_pin_i;
  logic [NCHG-1:0] chg_lvl, change_port_i;
  logic [PC_W-1:0] return_pc_i, stack_top_o;
  logic irq_high_o, irq_low_o, wake_o, stack_full_o, restore_valid_o;
  int mismatches;
  int comparisons;
  logic [DATA_W-1:0] rst_tab [9] = '{8'h1c, 8'h00, 8'he5, 8'hc0, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};

  etpis_top etpis_top_i (.ref_clk_i, .sys_rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .ext_irq_pin_i,
    .change_port_i, .sleep_i, .wdt_timeout_i, .reset_instr_i, .irq_entry_i, .irq_return_i, .fast_return_i,
    .return_pc_i, .working_reg_i, .status_reg_i, .bank_select_reg_i, .rd_data_o, .irq_high_o, .irq_low_o,
    .wake_o, .stack_top_o, .stack_full_o, .restore_valid_o, .working_reg_o, .status_reg_o, .bank_select_reg_o);
  etpis_pins_model etpis_pins_model_i (.ref_clk_i, .slow_i(slow), .ext_lvl_i(ext_lvl), .chg_lvl_i(chg_lvl),
    .ext_irq_pin_o(ext_irq_pin_i), .change_port_o(change_port_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), e, rd_data_o & m);
  endtask
  // Bounded wait, so a stuck output reports instead of hanging
  task automatic wait_bit(input string n, ref logic s, input logic v);
    for (int k = 0; k < 8 && s !== v; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk(n, v, s);
  endtask
  task automatic pins(input logic [NEXT-1:0] e, input logic [NCHG-1:0] c);
    @(posedge ref_clk_i);
    ext_lvl <= e;
    chg_lvl <= c;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic clr_flags();
    wr_reg(ADDR_CTLA, 8'h00);
    wr_reg(ADDR_CTLC, 8'hc0);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #40000;
    mismatches++;
    final_report();
  end

  initial begin
    {sys_rst_i, ce_i} = 2'h3;
    {wr_i, rd_i, sleep_i, slow, wdt_timeout_i, reset_instr_i, irq_entry_i, irq_return_i, fast_return_i} = '0;
    {addr_i, wdata_i, ext_lvl, chg_lvl, return_pc_i, working_reg_i, status_reg_i, bank_select_reg_i} = '0;
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) rd_chk(4'(i), 8'hff, rst_tab[i]);
    wr_reg(ADDR_RST_CTL, 8'hff);
    rd_chk(ADDR_RST_CTL, 8'hff, 8'h9f);
    @(posedge ref_clk_i);
    {wdt_timeout_i, reset_instr_i} <= 2'h3;
    @(posedge ref_clk_i);
    {wdt_timeout_i, reset_instr_i} <= 2'h0;
    rd_chk(ADDR_RST_CTL, 8'hff, 8'h87);
    wr_reg(ADDR_RST_CTL, 8'h00);
    rd_chk(ADDR_RST_CTL, 8'hff, 8'h04);
    // Frozen clock enable must drop the write
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    wr_reg(ADDR_RST_CTL, 8'h93);
    ce_i <= 1'b1;
    rd_chk(ADDR_RST_CTL, 8'hff, 8'h04);
    $display("reset register done");
    for (int p = 0; p < 2; p++) begin
      wr_reg(ADDR_CTLB, p[0] ? 8'he5 : 8'h05);
      pins({NEXT{p[0]}}, chg_lvl);
      clr_flags();
      pins({NEXT{~p[0]}}, chg_lvl);
      rd_chk(ADDR_CTLA, 8'h02, 8'h00);
      rd_chk(ADDR_CTLC, 8'h03, 8'h00);
      pins({NEXT{p[0]}}, chg_lvl);
      rd_chk(ADDR_CTLA, 8'h02, 8'h02);
      rd_chk(ADDR_CTLC, 8'h03, 8'h03);
      clr_flags();
      repeat (4) @(posedge ref_clk_i);
      rd_chk(ADDR_CTLA, 8'h02, 8'h00);
    end
    $display("edge select done");
    slow <= 1'b1;
    for (int j = 0; j < NCHG; j++) begin
      wr_reg(ADDR_CTLA, 8'h00);
      pins(ext_lvl, chg_lvl ^ 4'(1 << j));
      rd_chk(ADDR_CTLA, 8'h01, 8'h01);
    end
    slow <= 1'b0;
    $display("port change done");
    wr_reg(ADDR_TLO, 8'hfd);
    wr_reg(ADDR_TCTL, 8'hc0);
    repeat (6) @(posedge ref_clk_i);
    rd_chk(ADDR_CTLA, 8'h04, 8'h04);
    // Low byte wraps but the pair never reaches 0xffff
    wr_reg(ADDR_TCTL, 8'h00);
    wr_reg(ADDR_CTLA, 8'h00);
    wr_reg(ADDR_THI, 8'h00);
    wr_reg(ADDR_TLO, 8'hfd);
    wr_reg(ADDR_TCTL, 8'h80);
    repeat (8) @(posedge ref_clk_i);
    rd_chk(ADDR_CTLA, 8'h04, 8'h00);
    wr_reg(ADDR_THI, 8'hff);
    wr_reg(ADDR_TLO, 8'hfd);
    repeat (6) @(posedge ref_clk_i);
    wr_reg(ADDR_TCTL, 8'h00);
    rd_chk(ADDR_CTLA, 8'h04, 8'h04);
    wr_reg(ADDR_RST_CTL, 8'h80);
    wr_reg(ADDR_CTLB, 8'he1);
    wr_reg(ADDR_CTLA, 8'he4);
    wait_bit("low", irq_low_o, 1'b1);
    chk("high", 1'b0, irq_high_o);
    wr_reg(ADDR_CTLB, 8'he5);
    wait_bit("high", irq_high_o, 1'b1);
    wr_reg(ADDR_CTLA, 8'hc4);
    wait_bit("high", irq_high_o, 1'b0);
    $display("timer done");
    pins(3'h0, chg_lvl);
    clr_flags();
    wr_reg(ADDR_CTLA, 8'hd0);
    pins(3'h1, chg_lvl);
    wait_bit("high", irq_high_o, 1'b1);
    chk("low", 1'b0, irq_low_o);
    wr_reg(ADDR_CTLA, 8'hc0);
    wr_reg(ADDR_CTLC, 8'h88);
    pins(3'h3, chg_lvl);
    wait_bit("low", irq_low_o, 1'b1);
    chk("high", 1'b0, irq_high_o);
    wr_reg(ADDR_CTLC, 8'hc9);
    wait_bit("high", irq_high_o, 1'b1);
    chk("low", 1'b0, irq_low_o);
    wr_reg(ADDR_RST_CTL, 8'h00);
    wr_reg(ADDR_CTLC, 8'h09);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("high", 1'b1, irq_high_o);
    chk("low", 1'b0, irq_low_o);
    wr_reg(ADDR_CTLC, 8'h01);
    wait_bit("high", irq_high_o, 1'b0);
    rd_chk(ADDR_CTLC, 8'h01, 8'h01);
    $display("priority done");
    pins(3'h2, chg_lvl);
    wr_reg(ADDR_CTLA, 8'h90);
    @(posedge ref_clk_i);
    sleep_i <= 1'b1;
    pins(3'h3, chg_lvl);
    wait_bit("wake", wake_o, 1'b1);
    wait_bit("high", irq_high_o, 1'b1);
    @(posedge ref_clk_i);
    sleep_i <= 1'b0;
    $display("wake done");
    @(posedge ref_clk_i);
    irq_entry_i <= 1'b1;
    return_pc_i <= 21'h1_2345;
    {working_reg_i, status_reg_i, bank_select_reg_i} <= 24'ha5_5a3c;
    @(posedge ref_clk_i);
    return_pc_i <= 21'h0_0abc;
    {working_reg_i, status_reg_i, bank_select_reg_i} <= 24'h11_2233;
    @(posedge ref_clk_i);
    irq_entry_i <= 1'b0;
    #1;
    chk("stack top", 21'h0_0abc, stack_top_o);
    chk("shadow", 24'h11_2233, {working_reg_o, status_reg_o, bank_select_reg_o});
    @(posedge ref_clk_i);
    {irq_return_i, fast_return_i} <= 2'h3;
    @(posedge ref_clk_i);
    {irq_return_i, fast_return_i} <= 2'h0;
    #1;
    chk("stack top", 21'h1_2345, stack_top_o);
    wait_bit("restore", restore_valid_o, 1'b1);
    @(posedge ref_clk_i);
    irq_return_i <= 1'b1;
    @(posedge ref_clk_i);
    irq_return_i <= 1'b0;
    #1;
    chk("stack top", 21'h0_0000, stack_top_o);
    chk("restore", 1'b0, restore_valid_o);
    @(posedge ref_clk_i);
    irq_entry_i <= 1'b1;
    repeat (STK_DEPTH) @(posedge ref_clk_i);
    irq_entry_i <= 1'b0;
    #1;
    chk("full", 1'b1, stack_full_o);
    $display("context done");
    final_report();
  end
endmodule // etpis_top_tb
